// file: hdl/prs_pkg.sv
// Constants, field layouts and carrier types for the PHY reset sequencer.
// Assumes one 20 MHz reference clock and a byte-addressed register port, four bytes per register index.
package prs_pkg;

   localparam int CLK_PERIOD_NS = 50;
   localparam int MAC_RELEASE_NS = 640;
   // A longest time rounds down to whole cycles.
   localparam int MAC_RELEASE_CYC = MAC_RELEASE_NS / CLK_PERIOD_NS;
   // Pin to output latency: two synchroniser stages, state register, output register, margin.
   localparam int SEQ_LAT_CYC = 5;
   localparam int EXIT_LAST_CYC = MAC_RELEASE_CYC - SEQ_LAT_CYC;
   localparam int POR_HOLD_US = 20;
   localparam int POR_HOLD_CYC = (POR_HOLD_US * 1000) / CLK_PERIOD_NS;
   localparam int CLK_WAIT_MS = 53;
   localparam int CLK_WAIT_CYC = (CLK_WAIT_MS * 1000000) / CLK_PERIOD_NS;
   localparam int HW_LOW_MIN = 5;
   localparam int SW_HOLD_CYC = 2;

   localparam int CNT_W = 21;
   localparam int HWC_W = 3;

   // Exit step positions, in cycles after the exit phase starts.
   localparam int STEP_ADDR = 1;
   localparam int STEP_ENABLE = 2;
   localparam int STEP_DEFAULTS = 3;
   localparam int STEP_LINE_TX = 4;
   localparam int STEP_PLL = 5;

   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int PHY_ADDR_W = 5;
   localparam logic [ADDR_W-1:0] IDX_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] IDX_EXT_CONTROL = 8'h10;
   localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h11;

   localparam int CTRL_SW_RESET_BIT = 15;
   localparam int CTRL_POWER_DOWN_BIT = 11;
   localparam int EXT_ADDR_LSB = 6;
   localparam int STAT_LATCH_LOW_BIT = 0;
   localparam int STAT_LATCH_HIGH_BIT = 1;
   localparam int STAT_LATCH_MAX_LSB = 2;
   localparam int STAT_MGMT_READY_BIT = 8;
   localparam int STAT_CLOCKS_VALID_BIT = 9;

   localparam logic [DATA_W-1:0] CONTROL_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] EXT_CONTROL_RESET = 16'h0000;
   localparam logic LATCH_LOW_DEFAULT = 1'b0;
   localparam logic LATCH_HIGH_DEFAULT = 1'b0;
   localparam logic [3:0] LATCH_MAX_DEFAULT = 4'h0;

   typedef enum logic [5:0] {
      S_POR = 6'h01,
      S_HW_RESET = 6'h02,
      S_SW_RESET = 6'h04,
      S_EXIT = 6'h08,
      S_WAIT_CLK = 6'h10,
      S_RUN = 6'h20
   } prs_state_t;

   typedef struct packed {
      logic [3:0] txd;
      logic tx_en;
      logic tx_er;
   } prs_mac_in_t;

   typedef struct packed {
      logic [3:0] rxd;
      logic rx_dv;
      logic rx_er;
      logic crs;
      logic col;
   } prs_mac_out_t;

   typedef struct packed {
      logic level;
      logic high_evt;
      logic [3:0] value;
   } prs_stat_in_t;

endpackage : prs_pkg

// file: hdl/prs_hw_reset_filter.sv
// Synchroniser and low-sample counter for the hardware reset input.
// Assumes the pin may change at any time relative to the clock.
`timescale 1ns/100ps
`default_nettype none
module prs_hw_reset_filter (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pin_low,
   output logic pin_high,
   output logic asserted
);

   logic sync1_q;
   logic sync2_q;
   logic [prs_pkg::HWC_W-1:0] low_cnt_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else begin
         sync1_q <= pin_low;
         sync2_q <= sync1_q;
      end
   end

   // Saturates at the minimum so a long reset never wraps back to idle.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         low_cnt_q <= '0;
      end else if (sync2_q) begin
         low_cnt_q <= '0;
      end else if (low_cnt_q != prs_pkg::HWC_W'(prs_pkg::HW_LOW_MIN)) begin
         low_cnt_q <= low_cnt_q + 1'b1;
      end
   end

   assign pin_high = sync2_q;
   // Drops as soon as the synchronised pin reads high, so the exit is not held off
   // for the extra cycle that the counter needs to clear.
   assign asserted = (low_cnt_q == prs_pkg::HWC_W'(prs_pkg::HW_LOW_MIN)) && !sync2_q;

endmodule : prs_hw_reset_filter
`default_nettype wire

// file: hdl/prs_reset_sequencer.sv
// Reset sequencer of a 10/100 PHY: power-on, pin and software reset sources,
// single-cycle entry and ordered exit steps, and the control and extended control registers.
// Assumes the register master and the MAC datapath run on CLK.
`timescale 1ns/100ps
`default_nettype none
module prs_reset_sequencer #(
   parameter int CLK_WAIT_CYC = prs_pkg::CLK_WAIT_CYC
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic HW_RESET_IN_LOW,
   input wire logic [prs_pkg::PHY_ADDR_W-1:0] PHY_ADDR_STRAP,
   input wire logic [prs_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [prs_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [prs_pkg::DATA_W-1:0] REG_RDATA,
   input wire prs_pkg::prs_mac_in_t MAC_IN,
   output prs_pkg::prs_mac_in_t MAC_IN_CORE,
   input wire prs_pkg::prs_mac_out_t CORE_MAC_OUT,
   output prs_pkg::prs_mac_out_t MAC_OUT,
   input wire logic CORE_LINE_TX_P,
   input wire logic CORE_LINE_TX_N,
   output logic LINE_TRANSMIT_POSITIVE_O,
   output logic LINE_TRANSMIT_NEGATIVE_O,
   output logic LINE_TRANSMIT_OE_B,
   input wire prs_pkg::prs_stat_in_t STAT_IN,
   output logic CORE_RESET_B,
   output logic POWER_DOWN,
   output logic PLL_RESYNC,
   output logic MGMT_READY,
   output logic MAC_CLOCKS_VALID
);

   prs_pkg::prs_state_t state_q;
   prs_pkg::prs_state_t state_d;
   logic [prs_pkg::CNT_W-1:0] cnt_q;
   logic [prs_pkg::CNT_W-1:0] cnt_d;
   logic soft_q;
   logic pin_high;
   logic pin_asserted;
   logic sw_request;
   logic exit_done;
   logic ready;
   logic in_entry;
   logic pd_reset;
   logic addr_capture;
   logic core_enable;
   logic defaults_hold;
   logic line_enable;
   logic pll_hold;
   logic mac_release;
   logic wr_ok;
   logic [prs_pkg::DATA_W-1:0] control_q;
   logic [prs_pkg::DATA_W-1:0] ext_control_q;
   logic latch_low_q;
   logic latch_high_q;
   logic [3:0] latch_max_q;
   logic latch_init;
   logic stat_read;

   function automatic logic [prs_pkg::ADDR_W-1:0] reg_addr(
      input logic [prs_pkg::ADDR_W-1:0] idx
   );
      reg_addr = {idx[prs_pkg::ADDR_W-3:0], 2'b00};
   endfunction : reg_addr

   function automatic logic cnt_at(
      input logic [prs_pkg::CNT_W-1:0] cnt,
      input int limit
   );
      cnt_at = (cnt == prs_pkg::CNT_W'(limit));
   endfunction : cnt_at

   // True once an exit step has been reached, and stays true after the exit phase.
   function automatic logic step_done(
      input prs_pkg::prs_state_t st,
      input logic [prs_pkg::CNT_W-1:0] cnt,
      input int step
   );
      step_done = ((st == prs_pkg::S_EXIT) && (cnt >= prs_pkg::CNT_W'(step)))
         || (st == prs_pkg::S_WAIT_CLK) || (st == prs_pkg::S_RUN);
   endfunction : step_done

   prs_hw_reset_filter u_filter (
      .clk(CLK),
      .rst_b(RST_B),
      .pin_low(HW_RESET_IN_LOW),
      .pin_high(pin_high),
      .asserted(pin_asserted)
   );

   assign ready = (state_q == prs_pkg::S_WAIT_CLK) || (state_q == prs_pkg::S_RUN);
   assign wr_ok = REG_WR && ready;
   // Only a one written to bit 0.15 starts a reset; zero has no effect.
   assign sw_request = wr_ok && (REG_ADDR == reg_addr(prs_pkg::IDX_CONTROL))
      && REG_WDATA[prs_pkg::CTRL_SW_RESET_BIT];
   assign exit_done = (state_q == prs_pkg::S_EXIT)
      && cnt_at(cnt_q, prs_pkg::EXIT_LAST_CYC);

   always_comb begin
      state_d = state_q;
      case (state_q)
         prs_pkg::S_POR: begin
            // The pin is not looked at until the power-on hold ends.
            if (cnt_at(cnt_q, prs_pkg::POR_HOLD_CYC - 1)) begin
               state_d = prs_pkg::S_EXIT;
            end
         end
         prs_pkg::S_HW_RESET: begin
            if (pin_high) begin
               state_d = prs_pkg::S_EXIT;
            end
         end
         prs_pkg::S_SW_RESET: begin
            if (cnt_at(cnt_q, prs_pkg::SW_HOLD_CYC - 1)) begin
               state_d = prs_pkg::S_EXIT;
            end
         end
         prs_pkg::S_EXIT: begin
            if (exit_done) begin
               state_d = prs_pkg::S_WAIT_CLK;
            end
         end
         prs_pkg::S_WAIT_CLK: begin
            // A software request wins, or its accepted bit 0.15 would never clear.
            if (sw_request) begin
               state_d = prs_pkg::S_SW_RESET;
            end else if (cnt_at(cnt_q, CLK_WAIT_CYC - 1)) begin
               state_d = prs_pkg::S_RUN;
            end
         end
         prs_pkg::S_RUN: begin
            if (sw_request) begin
               state_d = prs_pkg::S_SW_RESET;
            end
         end
         default: begin
            state_d = prs_pkg::S_POR;
         end
      endcase
      // The pin wins over every source but power-on.
      if ((state_q != prs_pkg::S_POR) && pin_asserted) begin
         state_d = prs_pkg::S_HW_RESET;
      end
   end

   always_comb begin
      if (state_d != state_q) begin
         cnt_d = '0;
      end else if ((state_q == prs_pkg::S_RUN) || (state_q == prs_pkg::S_HW_RESET)) begin
         cnt_d = cnt_q;
      end else begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= prs_pkg::S_POR;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Remembers that the running reset came from software.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         soft_q <= 1'b0;
      end else if (state_d == prs_pkg::S_HW_RESET) begin
         soft_q <= 1'b0;
      end else if ((state_d == prs_pkg::S_SW_RESET) && (state_q != prs_pkg::S_SW_RESET)) begin
         soft_q <= 1'b1;
      end else if (exit_done) begin
         soft_q <= 1'b0;
      end
   end

   assign in_entry = (state_q == prs_pkg::S_POR) || (state_q == prs_pkg::S_HW_RESET)
      || (state_q == prs_pkg::S_SW_RESET);
   // Power-down is left as the first exit action, and never entered by software reset.
   assign pd_reset = (state_q == prs_pkg::S_POR) || (state_q == prs_pkg::S_HW_RESET);
   assign addr_capture = (state_q == prs_pkg::S_EXIT) && !soft_q
      && cnt_at(cnt_q, prs_pkg::STEP_ADDR);
   assign core_enable = step_done(state_q, cnt_q, prs_pkg::STEP_ENABLE);
   assign defaults_hold = in_entry || !step_done(state_q, cnt_q, prs_pkg::STEP_DEFAULTS);
   assign line_enable = step_done(state_q, cnt_q, prs_pkg::STEP_LINE_TX)
      && !control_q[prs_pkg::CTRL_POWER_DOWN_BIT];
   assign pll_hold = !step_done(state_q, cnt_q, prs_pkg::STEP_PLL);
   assign mac_release = ready && !control_q[prs_pkg::CTRL_POWER_DOWN_BIT];
   assign latch_init = in_entry || control_q[prs_pkg::CTRL_POWER_DOWN_BIT];
   assign stat_read = REG_RD && (REG_ADDR == reg_addr(prs_pkg::IDX_STATUS));

   // Control register: defaults are held through entry and the early exit steps.
   // The software reset bit stays set until the exit ends, then reads zero.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         control_q <= prs_pkg::CONTROL_RESET;
      end else if (defaults_hold || exit_done) begin
         control_q <= prs_pkg::CONTROL_RESET;
         control_q[prs_pkg::CTRL_SW_RESET_BIT] <= soft_q && !exit_done;
      end else if (wr_ok && (REG_ADDR == reg_addr(prs_pkg::IDX_CONTROL))) begin
         control_q <= REG_WDATA;
      end
   end

   // The address field survives a software reset and, once captured, the later
   // default steps of the exit; other bits take defaults.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ext_control_q <= prs_pkg::EXT_CONTROL_RESET;
      end else if (addr_capture) begin
         ext_control_q[prs_pkg::EXT_ADDR_LSB +: prs_pkg::PHY_ADDR_W] <= PHY_ADDR_STRAP;
      end else if (in_entry && !soft_q) begin
         ext_control_q <= prs_pkg::EXT_CONTROL_RESET;
      end else if (defaults_hold) begin
         ext_control_q <= (prs_pkg::EXT_CONTROL_RESET
            & ~(16'h001f << prs_pkg::EXT_ADDR_LSB))
            | (ext_control_q & (16'h001f << prs_pkg::EXT_ADDR_LSB));
      end else if (wr_ok && (REG_ADDR == reg_addr(prs_pkg::IDX_EXT_CONTROL))) begin
         ext_control_q <= REG_WDATA;
      end
   end

   // Latching status: a hardware event in the cycle of a read is kept.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         latch_low_q <= prs_pkg::LATCH_LOW_DEFAULT;
         latch_high_q <= prs_pkg::LATCH_HIGH_DEFAULT;
         latch_max_q <= prs_pkg::LATCH_MAX_DEFAULT;
      end else if (latch_init) begin
         latch_low_q <= prs_pkg::LATCH_LOW_DEFAULT;
         latch_high_q <= prs_pkg::LATCH_HIGH_DEFAULT;
         latch_max_q <= prs_pkg::LATCH_MAX_DEFAULT;
      end else begin
         if (!STAT_IN.level) begin
            latch_low_q <= 1'b0;
         end else if (stat_read) begin
            latch_low_q <= 1'b1;
         end
         if (STAT_IN.high_evt) begin
            latch_high_q <= 1'b1;
         end else if (stat_read) begin
            latch_high_q <= 1'b0;
         end
         if (stat_read) begin
            latch_max_q <= STAT_IN.value;
         end else if (STAT_IN.value > latch_max_q) begin
            latch_max_q <= STAT_IN.value;
         end
      end
   end

   // Read data stand only in the cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         REG_RDATA <= '0;
      end else if (!REG_RD) begin
         REG_RDATA <= '0;
      end else if (REG_ADDR == reg_addr(prs_pkg::IDX_CONTROL)) begin
         REG_RDATA <= control_q;
      end else if (REG_ADDR == reg_addr(prs_pkg::IDX_EXT_CONTROL)) begin
         REG_RDATA <= ext_control_q;
      end else if (REG_ADDR == reg_addr(prs_pkg::IDX_STATUS)) begin
         REG_RDATA <= '0;
         REG_RDATA[prs_pkg::STAT_LATCH_LOW_BIT] <= latch_low_q;
         REG_RDATA[prs_pkg::STAT_LATCH_HIGH_BIT] <= latch_high_q;
         REG_RDATA[prs_pkg::STAT_LATCH_MAX_LSB +: 4] <= latch_max_q;
         REG_RDATA[prs_pkg::STAT_MGMT_READY_BIT] <= ready;
         REG_RDATA[prs_pkg::STAT_CLOCKS_VALID_BIT] <= (state_q == prs_pkg::S_RUN);
      end else begin
         REG_RDATA <= '0;
      end
   end

   // MAC side: inputs isolated and outputs low until release.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         MAC_IN_CORE <= '0;
         MAC_OUT <= '0;
      end else if (mac_release) begin
         MAC_IN_CORE <= MAC_IN;
         MAC_OUT <= CORE_MAC_OUT;
      end else begin
         MAC_IN_CORE <= '0;
         MAC_OUT <= '0;
      end
   end

   // Line pair: enable is low while driving; tri-stated through reset and power-down.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         LINE_TRANSMIT_POSITIVE_O <= 1'b0;
         LINE_TRANSMIT_NEGATIVE_O <= 1'b0;
         LINE_TRANSMIT_OE_B <= 1'b1;
      end else begin
         LINE_TRANSMIT_POSITIVE_O <= line_enable & CORE_LINE_TX_P;
         LINE_TRANSMIT_NEGATIVE_O <= line_enable & CORE_LINE_TX_N;
         LINE_TRANSMIT_OE_B <= !line_enable;
      end
   end

   // The clocks-valid flag tells the MAC when its interface may be used.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         CORE_RESET_B <= 1'b0;
         POWER_DOWN <= 1'b1;
         PLL_RESYNC <= 1'b1;
         MGMT_READY <= 1'b0;
         MAC_CLOCKS_VALID <= 1'b0;
      end else begin
         CORE_RESET_B <= core_enable;
         POWER_DOWN <= pd_reset || control_q[prs_pkg::CTRL_POWER_DOWN_BIT];
         PLL_RESYNC <= pll_hold;
         MGMT_READY <= ready;
         MAC_CLOCKS_VALID <= (state_q == prs_pkg::S_RUN);
      end
   end

endmodule : prs_reset_sequencer
`default_nettype wire

// file: bench/prs_reset_sequencer_properties.sv
// Port assertions for the reset sequencer.
// Bound to every prs_reset_sequencer instance; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module prs_checker #(
   parameter int CLK_WAIT_CYC = 20
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic HW_RESET_IN_LOW,
   input wire logic [7:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [15:0] REG_RDATA,
   input wire prs_pkg::prs_mac_in_t MAC_IN_CORE,
   input wire prs_pkg::prs_mac_out_t MAC_OUT,
   input wire logic LINE_TRANSMIT_POSITIVE_O,
   input wire logic LINE_TRANSMIT_NEGATIVE_O,
   input wire logic LINE_TRANSMIT_OE_B,
   input wire logic CORE_RESET_B,
   input wire logic POWER_DOWN,
   input wire logic PLL_RESYNC,
   input wire logic MGMT_READY,
   input wire logic MAC_CLOCKS_VALID
);
   logic sw_req;
   logic [20:0] wait_q;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   assign sw_req = REG_WR && REG_ADDR == 8'h00 && REG_WDATA[15] && !REG_WDATA[11] && MGMT_READY;
   // Counts ready cycles spent waiting for the MAC clocks.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         wait_q <= '0;
      end else if (!MGMT_READY) begin
         wait_q <= '0;
      end else if (!MAC_CLOCKS_VALID) begin
         wait_q <= wait_q + 21'h1;
      end
   end
   a_mac_isolated: assert property ((!MGMT_READY)[*2] |->
      MAC_OUT == '0 && MAC_IN_CORE == '0) else $error("MAC pins not held");
   a_line_quiet: assert property (LINE_TRANSMIT_OE_B |->
      !LINE_TRANSMIT_POSITIVE_O && !LINE_TRANSMIT_NEGATIVE_O) else $error("line driven");
   a_pin_enters: assert property ((!HW_RESET_IN_LOW)[*8] |-> ##[0:6] !MGMT_READY)
      else $error("pin reset not entered");
   a_pin_exit_time: assert property ($rose(HW_RESET_IN_LOW) |->
      ##[1:12] (MGMT_READY && !LINE_TRANSMIT_OE_B)) else $error("exit too slow");
   a_pd_exit_first: assert property ($fell(POWER_DOWN) && !MGMT_READY |->
      PLL_RESYNC && LINE_TRANSMIT_OE_B && !CORE_RESET_B) else $error("exit order");
   a_ready_steps: assert property ($rose(MGMT_READY) |-> CORE_RESET_B &&
      !PLL_RESYNC && !LINE_TRANSMIT_OE_B && !POWER_DOWN) else $error("steps missing");
   a_clocks_locked: assert property (MAC_CLOCKS_VALID |-> MGMT_READY && !PLL_RESYNC)
      else $error("clocks valid early");
   a_clock_wait: assert property ($rose(MAC_CLOCKS_VALID) |->
      wait_q >= CLK_WAIT_CYC - 2 && wait_q <= CLK_WAIT_CYC + 2) else $error("clock wait");
   a_sw_no_pd: assert property (sw_req |-> ##1 (!POWER_DOWN)[*8])
      else $error("software reset powered down");
   a_sw_hold: assert property (sw_req |-> ##[1:3] !CORE_RESET_B ##[1:8] CORE_RESET_B)
      else $error("software reset hold");
   a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == '0)
      else $error("read data outside slot");
   c_ready: cover property ($rose(MGMT_READY));
   c_sw: cover property (sw_req);
   c_clocks: cover property ($rose(MAC_CLOCKS_VALID));
endmodule : prs_checker
bind prs_reset_sequencer prs_checker #(.CLK_WAIT_CYC(CLK_WAIT_CYC)) u_chk (.CLK, .RST_B,
   .HW_RESET_IN_LOW, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .MAC_IN_CORE,
   .MAC_OUT, .LINE_TRANSMIT_POSITIVE_O, .LINE_TRANSMIT_NEGATIVE_O, .LINE_TRANSMIT_OE_B,
   .CORE_RESET_B, .POWER_DOWN, .PLL_RESYNC, .MGMT_READY, .MAC_CLOCKS_VALID);
`default_nettype wire

// file: bench/prs_mac_model.sv
// MAC and PHY core stand-in: pin traffic that changes every cycle.
// Assumes the sequencer's clock and clocks-valid flag.
`timescale 1ns/100ps
`default_nettype none
module prs_mac_model (
   input wire logic clk,
   input wire logic clocks_valid,
   output prs_pkg::prs_mac_in_t mac_in,
   output prs_pkg::prs_mac_out_t core_out,
   output logic core_tx_p,
   output logic core_tx_n
);
   logic [7:0] cnt_q = 8'h00;
   always_ff @(posedge clk) cnt_q <= cnt_q + 8'h01;
   // The MAC stays silent until both clocks are valid.
   assign mac_in = clocks_valid ? cnt_q[5:0] : 6'h00;
   assign core_out = cnt_q ^ 8'h5a;
   assign core_tx_p = cnt_q[0];
   assign core_tx_n = ~cnt_q[0];
endmodule : prs_mac_model
`default_nettype wire

// file: bench/tb_prs_reset_sequencer.sv
// Self-checking bench for the reset sequencer.
// Assumes a shortened clock wait and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_prs_reset_sequencer;
   localparam int CW = 20;
   logic clk, rst_b, pin_low, reg_wr, reg_rd, p_o, n_o, oe_b, core_p, core_n;
   logic core_rst_b, pd, pll, ready, clk_ok;
   logic [4:0] strap;
   logic [7:0] reg_addr;
   logic [15:0] wdata, rdata, d;
   prs_pkg::prs_mac_in_t mac_in, mac_in_core;
   prs_pkg::prs_mac_out_t core_out, mac_out;
   prs_pkg::prs_stat_in_t stat;
   int failures = 0;
   int check_count = 0;
   prs_reset_sequencer #(.CLK_WAIT_CYC(CW)) dut (.CLK(clk), .RST_B(rst_b),
      .HW_RESET_IN_LOW(pin_low), .PHY_ADDR_STRAP(strap), .REG_ADDR(reg_addr),
      .REG_WDATA(wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
      .MAC_IN(mac_in), .MAC_IN_CORE(mac_in_core), .CORE_MAC_OUT(core_out),
      .MAC_OUT(mac_out), .CORE_LINE_TX_P(core_p), .CORE_LINE_TX_N(core_n),
      .LINE_TRANSMIT_POSITIVE_O(p_o), .LINE_TRANSMIT_NEGATIVE_O(n_o),
      .LINE_TRANSMIT_OE_B(oe_b), .STAT_IN(stat), .CORE_RESET_B(core_rst_b),
      .POWER_DOWN(pd), .PLL_RESYNC(pll), .MGMT_READY(ready), .MAC_CLOCKS_VALID(clk_ok));
   prs_mac_model u_mac (.clk(clk), .clocks_valid(clk_ok), .mac_in(mac_in),
      .core_out(core_out), .core_tx_p(core_p), .core_tx_n(core_n));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd
   task automatic wait_ready(input int lim);
      int i;
      i = 0;
      while (ready !== 1'b1 && i < lim) begin
         @(posedge clk);
         #1;
         i++;
      end
      `CHK("ready", 1'b1, ready)
   endtask : wait_ready
   task automatic event_pulse;
      @(posedge clk);
      stat.high_evt <= 1'b1;
      @(posedge clk);
      stat.high_evt <= 1'b0;
   endtask : event_pulse
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      end_sim();
   end
   initial begin
      rst_b = 1'b0;
      pin_low = 1'b1;
      strap = 5'h13;
      reg_addr = 8'h00;
      wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      stat = '0;
      repeat (4) @(posedge clk);
      #1;
      `CHK("reset outs", 6'b011010, {ready, pd, oe_b, core_rst_b, pll, clk_ok})
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (300) @(posedge clk);
      #1;
      `CHK("por hold", 1'b0, ready)
      wait_ready(200);
      rd(8'h40, d);
      `CHK("addr field", {5'h00, 5'h13, 6'h00}, d)
      rd(8'h00, d);
      `CHK("control", 16'h0000, d)
      rd(8'h3c, d);
      `CHK("unmapped", 16'h0000, d)
      repeat (CW + 4) @(posedge clk);
      #1;
      `CHK("clocks valid", 1'b1, clk_ok)
      `CHK("mac out", 8'(u_mac.cnt_q - 8'h01) ^ 8'h5a, mac_out)
      `CHK("mac in", 6'(u_mac.cnt_q - 8'h01), mac_in_core)
      `CHK("line out", {~u_mac.cnt_q[0], u_mac.cnt_q[0]}, {p_o, n_o})
      // Software reset keeps the first strap value despite the new one.
      strap <= 5'h0a;
      wr(8'h00, 16'h8000);
      rd(8'h00, d);
      `CHK("sw bit set", 1'b1, d[15])
      for (int i = 0; i < 20 && d[15] !== 1'b0; i++) begin
         rd(8'h00, d);
      end
      `CHK("sw bit clear", 16'h0000, d)
      rd(8'h40, d);
      `CHK("addr kept", {5'h00, 5'h13, 6'h00}, d)
      @(posedge clk);
      pin_low <= 1'b0;
      repeat (3) @(posedge clk);
      pin_low <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      `CHK("short pulse", 1'b1, ready)
      event_pulse();
      pin_low <= 1'b0;
      repeat (12) @(posedge clk);
      #1;
      `CHK("pin reset", 6'b011010, {ready, pd, oe_b, core_rst_b, pll, clk_ok})
      `CHK("mac zero", 8'h00, mac_out)
      `CHK("mac in zero", 6'h00, mac_in_core)
      `CHK("line zero", 2'b00, {p_o, n_o})
      wr(8'h00, 16'h0800);
      pin_low <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      `CHK("exit ready", 1'b1, ready)
      rd(8'h40, d);
      `CHK("addr recapture", {5'h00, 5'h0a, 6'h00}, d)
      rd(8'h00, d);
      `CHK("write dropped", 16'h0000, d)
      rd(8'h44, d);
      `CHK("latch reinit", 1'b0, d[1])
      event_pulse();
      rd(8'h44, d);
      `CHK("latch set", 2'b11, {d[8], d[1]})
      rd(8'h44, d);
      `CHK("latch clear", 1'b0, d[1])
      // The power-down bit quiets the pins and holds the latching bits at their defaults.
      wr(8'h00, 16'h0800);
      @(posedge clk);
      #1;
      `CHK("pd bit", 11'h700, {ready, pd, oe_b, mac_out})
      event_pulse();
      rd(8'h44, d);
      `CHK("pd latch", 1'b0, d[1])
      end_sim();
   end
endmodule : tb_prs_reset_sequencer
`default_nettype wire
